// File: logic/seg_command_guard.sv
// power-up and command acceptance guard of a serial eeprom
`timescale 1ns/1ps
`include "seg_regs.svh"
module seg_command_guard
    import seg_pkg::*;
#(
    parameter int WriteCycles = `SEG_WRITE_CYCLES
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // supply monitor
    input wire logic supplyOk,
    // serial pins
    input wire logic chipSelectN,
    input wire logic serialClk,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOutEn,
    // status and memory side
    output logic [7:0] statusByte,
    output logic writeStart,
    output logic arrayWriteGo,
    output logic statusWriteGo,
    output logic arrayReadGo,
    output logic standby
);
    // ==========================================================
    // opcode decode
    function automatic seg_cmd_t decode_op(input logic [7:0] op);
        unique case (op)
            `SEG_OP_WRITE_ENABLE_CODE: decode_op = SEG_CMD_WRITE_ENABLE;
            `SEG_OP_WRDI_CODE: decode_op = SEG_CMD_WRDI;
            `SEG_OP_RDSTAT_CODE: decode_op = SEG_CMD_RDSTAT;
            `SEG_OP_WRSTAT_CODE: decode_op = SEG_CMD_WRSTAT;
            `SEG_OP_READ_CODE: decode_op = SEG_CMD_READ;
            `SEG_OP_WRITE_CODE: decode_op = SEG_CMD_WRITE;
            default: decode_op = SEG_CMD_BAD;
        endcase
    endfunction

    // ==========================================================
    // state
    typedef struct packed {
        logic [1:0] csSync;
        logic [1:0] sckSync;
        logic [1:0] siSync;
        logic [1:0] pwrSync;
        logic csPrev;
        logic sckPrev;
        seg_power_t power;
        seg_cmd_t cmd;
        logic [7:0] shift;
        logic [15:0] bitCount;
        logic writeEnableLatch;
        logic [7:0] outShift;
        logic outEn;
        logic out;
        logic start;
        logic arrayGo;
        logic statGo;
        logic readGo;
        logic pendingClear;
    } seg_guard_state_t;
    seg_guard_state_t st_q;
    seg_guard_state_t st_d;
    seg_timer_if tmr();
    logic csRise;
    logic csFall;
    logic sckRise;
    logic sckFall;
    logic busy;
    logic [7:0] shiftNext;
    logic frameOk;
    assign busy = tmr.busy;
    assign csRise = st_q.csSync[1] & ~st_q.csPrev;
    assign csFall = ~st_q.csSync[1] & st_q.csPrev;
    assign sckRise = st_q.sckSync[1] & ~st_q.sckPrev;
    assign sckFall = ~st_q.sckSync[1] & st_q.sckPrev;
    assign shiftNext = {st_q.shift[6:0], st_q.siSync[1]};

    // ==========================================================
    // next state
    always_comb
    begin
        st_d = st_q;
        st_d.csSync = {st_q.csSync[0], chipSelectN};
        st_d.sckSync = {st_q.sckSync[0], serialClk};
        st_d.siSync = {st_q.siSync[0], serialIn};
        st_d.pwrSync = {st_q.pwrSync[0], supplyOk};
        st_d.csPrev = st_q.csSync[1];
        st_d.sckPrev = st_q.sckSync[1];
        st_d.start = 1'b0;
        st_d.arrayGo = 1'b0;
        st_d.statGo = 1'b0;
        st_d.readGo = 1'b0;
        frameOk = 1'b0;
        // write enable latch drops once the internal write has finished;
        // busy only rises the cycle after start, so start must hold it off
        if (st_q.pendingClear && !busy && !st_q.start)
        begin
            st_d.writeEnableLatch = 1'b0;
            st_d.pendingClear = 1'b0;
        end
        unique case (st_q.power)
            SEG_POR:
            begin
                st_d.writeEnableLatch = 1'b0;
                st_d.outEn = 1'b0;
                st_d.cmd = SEG_CMD_NONE;
                st_d.bitCount = 16'h0000;
                st_d.pendingClear = 1'b0;
                if (st_q.pwrSync[1])
                    st_d.power = SEG_WAIT_SELECT;
            end
            SEG_WAIT_SELECT:
            begin
                if (csFall)
                    st_d.power = SEG_READY;
            end
            SEG_READY:
            begin
                if (csFall)
                begin
                    st_d.cmd = SEG_CMD_NONE;
                    st_d.bitCount = 16'h0000;
                    st_d.outEn = 1'b0;
                end
                else if (!st_q.csSync[1] && sckRise && st_q.cmd != SEG_CMD_BAD)
                begin
                    st_d.shift = shiftNext;
                    st_d.bitCount = st_q.bitCount + 16'h0001;
                    if (st_q.bitCount == 16'(`SEG_OPCODE_BITS - 1))
                    begin
                        st_d.cmd = decode_op(shiftNext);
                        if (busy && decode_op(shiftNext) != SEG_CMD_RDSTAT)
                            st_d.cmd = SEG_CMD_BAD;
                        if (decode_op(shiftNext) == SEG_CMD_RDSTAT)
                        begin
                            st_d.outShift = statusByte;
                            st_d.outEn = 1'b1;
                        end
                        if (decode_op(shiftNext) == SEG_CMD_BAD)
                            st_d.outEn = 1'b0;
                    end
                    if (st_q.cmd == SEG_CMD_READ
                        && st_q.bitCount == 16'(`SEG_OPCODE_BITS + `SEG_ADDR_BITS - 1))
                    begin
                        st_d.readGo = 1'b1;
                        st_d.outEn = 1'b1;
                    end
                end
                else if (!st_q.csSync[1] && sckFall && st_q.outEn)
                begin
                    st_d.out = st_q.outShift[7];
                    st_d.outShift = {st_q.outShift[6:0], st_q.outShift[7]};
                end
                if (csRise)
                begin
                    st_d.outEn = 1'b0;
                    unique case (st_q.cmd)
                        SEG_CMD_WRITE_ENABLE:
                            if (st_q.bitCount == 16'(`SEG_OPCODE_BITS))
                                st_d.writeEnableLatch = 1'b1;
                        SEG_CMD_WRDI:
                            if (st_q.bitCount == 16'(`SEG_OPCODE_BITS))
                                st_d.writeEnableLatch = 1'b0;
                        SEG_CMD_WRSTAT:
                        begin
                            frameOk = st_q.bitCount == 16'(2 * `SEG_OPCODE_BITS);
                            if (frameOk && st_q.writeEnableLatch)
                            begin
                                st_d.start = 1'b1;
                                st_d.statGo = 1'b1;
                                st_d.pendingClear = 1'b1;
                            end
                        end
                        SEG_CMD_WRITE:
                        begin
                            frameOk = st_q.bitCount
                                >= 16'(2 * `SEG_OPCODE_BITS + `SEG_ADDR_BITS)
                                && st_q.bitCount[2:0] == 3'h0;
                            if (frameOk && st_q.writeEnableLatch)
                            begin
                                st_d.start = 1'b1;
                                st_d.arrayGo = 1'b1;
                                st_d.pendingClear = 1'b1;
                            end
                        end
                        default:
                        begin
                        end
                    endcase
                    st_d.cmd = SEG_CMD_NONE;
                end
            end
        endcase
        if (!st_q.pwrSync[1])
        begin
            st_d.power = SEG_POR;
            st_d.start = 1'b0;
            st_d.arrayGo = 1'b0;
            st_d.statGo = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st_q <= '0;
            st_q.csSync <= 2'h3;
            st_q.csPrev <= 1'b1;
            st_q.power <= SEG_POR;
            st_q.cmd <= SEG_CMD_NONE;
        end
        else
            st_q <= st_d;
    end

    // ==========================================================
    // internal write timer
    assign tmr.start = st_q.start;
    seg_write_timer #(.WriteCycles(WriteCycles)) u_timer (
        .mclk(mclk),
        .reset(reset),
        .tmr(tmr)
    );

    // ==========================================================
    // outputs
    always_comb
    begin
        statusByte = 8'h00;
        statusByte[`SEG_STAT_BUSY_BIT] = busy;
        statusByte[`SEG_STAT_LATCH_BIT] = st_q.writeEnableLatch;
    end
    assign serialOut = st_q.out;
    assign serialOutEn = st_q.outEn & ~st_q.csSync[1];
    assign writeStart = st_q.start;
    assign arrayWriteGo = st_q.arrayGo;
    assign statusWriteGo = st_q.statGo;
    assign arrayReadGo = st_q.readGo;
    assign standby = st_q.power != SEG_POR;
endmodule // seg_command_guard

// File: logic/seg_write_timer.sv
// self-timed internal write cycle counter
`timescale 1ns/1ps
`include "seg_regs.svh"
module seg_write_timer
    import seg_pkg::*;
#(
    parameter int WriteCycles = `SEG_WRITE_CYCLES
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // control
    seg_timer_if.timer tmr
);
    // the counter is 16 bits wide
    if (WriteCycles < 1 || WriteCycles > 65535)
    begin : gen_bad_cycles
        $error("WriteCycles out of range");
    end
    typedef struct packed {
        logic busy;
        logic [15:0] count;
    } seg_tmr_state_t;
    seg_tmr_state_t st_q;
    seg_tmr_state_t st_d;
    always_comb
    begin
        st_d = st_q;
        if (st_q.busy)
        begin
            // programming continues whatever happens on the pins
            if (st_q.count == 16'h0001)
                st_d.busy = 1'b0;
            st_d.count = st_q.count - 16'h0001;
        end
        else if (tmr.start)
        begin
            st_d.busy = 1'b1;
            st_d.count = 16'(WriteCycles);
        end
    end
    always_ff @(posedge mclk)
    begin
        if (reset)
            st_q <= '0;
        else
            st_q <= st_d;
    end
    assign tmr.busy = st_q.busy;
endmodule // seg_write_timer

// File: pkg/seg_pins_if.sv
// start and busy handshake between the guard and its write timer
`timescale 1ns/1ps
interface seg_timer_if;
    logic start;
    logic busy;
    modport guard (output start, input busy);
    modport timer (input start, output busy);
endinterface

// File: pkg/seg_pkg.sv
// types of the command guard
package seg_pkg;
    typedef enum logic [2:0] {
        SEG_CMD_NONE,
        SEG_CMD_WRITE_ENABLE,
        SEG_CMD_WRDI,
        SEG_CMD_RDSTAT,
        SEG_CMD_WRSTAT,
        SEG_CMD_READ,
        SEG_CMD_WRITE,
        SEG_CMD_BAD
    } seg_cmd_t;
    typedef enum logic [1:0] {
        SEG_POR,
        SEG_WAIT_SELECT,
        SEG_READY
    } seg_power_t;
endpackage

// File: pkg/seg_regs.svh
// timing counts, opcodes and status bit positions of the command guard
`ifndef SEG_REGS_SVH
`define SEG_REGS_SVH
`define SEG_OP_WRITE_ENABLE_CODE 8'h06
`define SEG_OP_WRDI_CODE 8'h04
`define SEG_OP_RDSTAT_CODE 8'h05
`define SEG_OP_WRSTAT_CODE 8'h01
`define SEG_OP_READ_CODE 8'h03
`define SEG_OP_WRITE_CODE 8'h02
`define SEG_STAT_BUSY_BIT 0
`define SEG_STAT_LATCH_BIT 1
`define SEG_WRITE_TIME_US 5
`define SEG_CLK_MHZ 40
`define SEG_WRITE_CYCLES (`SEG_WRITE_TIME_US * `SEG_CLK_MHZ)
`define SEG_OPCODE_BITS 8
`define SEG_ADDR_BITS 16
`endif

// File: verification/seg_command_guard_tb.sv
// self-checking bench of the command guard
`timescale 1ns/1ps
module seg_command_guard_tb;
    import seg_pkg::*;
    localparam int WriteCycles = 600;
    typedef struct {logic enableFirst; logic [47:0] bits; int n; logic [7:0] stat;
        logic [7:0] starts;
        logic [7:0] reads; logic oe;} seg_row_t;
    logic mclk = 1'b0, reset = 1'b1, supplyOk = 1'b0;
    logic chipSelectN, serialClk, serialIn, serialOut, serialOutEn, writeStart;
    logic arrayWriteGo, statusWriteGo, arrayReadGo, standby;
    logic [7:0] statusByte, rx;
    logic [7:0] nStart = 8'h00;
    logic [7:0] nRead = 8'h00;
    logic nOe = 1'b0;
    logic clearReq = 1'b0;
    int miscompares = 0, checksDone = 0, cycles = 0;
    seg_row_t rows [8] = '{
        '{1'b0, 48'h06, 8, 8'h02, 8'h00, 8'h00, 1'b0},
        '{1'b1, 48'h00c0, 15, 8'h02, 8'h00, 8'h00, 1'b0},
        '{1'b1, 48'h0200105a, 32, 8'h00, 8'h01, 8'h00, 1'b0},
        '{1'b0, 48'h0200105a, 32, 8'h00, 8'h00, 8'h00, 1'b0},
        '{1'b0, 48'ha5ff, 16, 8'h00, 8'h00, 8'h00, 1'b0},
        '{1'b1, 48'h0180, 16, 8'h00, 8'h01, 8'h00, 1'b0},
        '{1'b1, 48'h04, 8, 8'h00, 8'h00, 8'h00, 1'b0},
        '{1'b0, 48'h03001000, 32, 8'h00, 8'h00, 8'h01, 1'b1}};
    always #12.5 mclk = ~mclk;
    seg_command_guard #(.WriteCycles(WriteCycles)) DUT (.mclk(mclk), .reset(reset),
        .supplyOk(supplyOk), .chipSelectN(chipSelectN), .serialClk(serialClk),
        .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn),
        .statusByte(statusByte), .writeStart(writeStart), .arrayWriteGo(arrayWriteGo),
        .statusWriteGo(statusWriteGo), .arrayReadGo(arrayReadGo), .standby(standby));
    seg_host_model host (.mclk(mclk), .chipSelectN(chipSelectN), .serialClk(serialClk),
        .serialIn(serialIn), .serialOut(serialOut));
    // ==========================================
    // monitors and timeout
    always @(posedge mclk)
    begin
        if (clearReq)
        begin
            nStart <= 8'h00;
            nRead <= 8'h00;
            nOe <= 1'b0;
        end
        else
        begin
            nStart <= nStart + {7'h00, writeStart === 1'b1};
            nRead <= nRead + {7'h00, arrayReadGo === 1'b1};
            nOe <= nOe | (serialOutEn === 1'b1);
        end
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            miscompares++;
            closeOut();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic closeOut();
        if (miscompares == 0 && checksDone > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // the monitor clears the counters at the next edge
    task automatic clearCounts();
        clearReq = 1'b1;
        @(posedge mclk);
        #1 clearReq = 1'b0;
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        repeat (20) @(posedge mclk);
        #1 reset = 1'b0;
        host.tick(2);
        check(statusByte, 8'h00);
        check({7'h00, standby}, 8'h00);
        host.frame(48'h06, 8, rx);
        check(statusByte, 8'h00);
        supplyOk = 1'b1;
        host.tick(10);
        check({7'h00, standby}, 8'h01);
        host.frame(48'h06, 8, rx);
        host.tick(10);
        check(statusByte, 8'h02);
        foreach (rows[i])
        begin
            if (rows[i].enableFirst)
                host.frame(48'h06, 8, rx);
            clearCounts();
            host.frame(rows[i].bits, rows[i].n, rx);
            host.tick(WriteCycles + 100);
            check(statusByte, rows[i].stat);
            check(nStart, rows[i].starts);
            check(nRead, rows[i].reads);
            check({7'h00, nOe}, {7'h00, rows[i].oe});
        end
        host.frame(48'h06, 8, rx);
        host.frame(48'h0200105a, 32, rx);
        clearCounts();
        host.frame(48'h06, 8, rx);
        host.frame(48'h030010, 24, rx);
        check(nRead, 8'h00);
        host.frame(48'h0500, 16, rx);
        check(rx, 8'h03);
        host.tick(WriteCycles);
        check(statusByte, 8'h00);
        host.frame(48'h06, 8, rx);
        supplyOk = 1'b0;
        host.tick(10);
        check(statusByte, 8'h00);
        check({7'h00, standby}, 8'h00);
        closeOut();
    end
endmodule // seg_command_guard_tb
bind seg_command_guard seg_guard_assertions #(.WriteCycles(WriteCycles)) chk (.mclk(mclk),
    .reset(reset), .supplyOk(supplyOk), .serialOutEn(serialOutEn), .statusByte(statusByte),
    .writeStart(writeStart), .arrayWriteGo(arrayWriteGo), .statusWriteGo(statusWriteGo),
    .arrayReadGo(arrayReadGo), .standby(standby));

// File: verification/seg_guard_assertions.sv
// concurrent checks on the command guard ports
`timescale 1ns/1ps
module seg_guard_assertions
    import seg_pkg::*;
#(
    parameter int WriteCycles = 200
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // pins and status
    input wire logic supplyOk,
    input wire logic serialOutEn,
    input wire logic [7:0] statusByte,
    input wire logic writeStart,
    input wire logic arrayWriteGo,
    input wire logic statusWriteGo,
    input wire logic arrayReadGo,
    input wire logic standby
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // ==========================================
    // busy length counter
    logic [15:0] busyCnt_q;
    always_ff @(posedge mclk)
    begin
        if (reset || !statusByte[0])
            busyCnt_q <= 16'h0000;
        else
            busyCnt_q <= busyCnt_q + 16'h0001;
    end
    // ==========================================
    // properties
    AST_START_KIND: assert property (writeStart |-> (arrayWriteGo ^ statusWriteGo))
        else $error("write start without exactly one write kind");
    AST_GO_NEEDS_START: assert property ((arrayWriteGo || statusWriteGo) |-> writeStart)
        else $error("write kind pulse without write start");
    AST_START_NEEDS_WEL: assert property (writeStart |-> statusByte[1])
        else $error("write started with latch clear");
    AST_BUSY_FOLLOWS: assert property (writeStart |=> statusByte[0])
        else $error("busy bit did not rise after write start");
    AST_BUSY_LENGTH: assert property ($fell(statusByte[0]) |-> busyCnt_q == WriteCycles)
        else $error("internal write length wrong");
    AST_LATCH_CLEARS: assert property ($fell(statusByte[0]) |=> !statusByte[1])
        else $error("latch still set after write");
    AST_NO_START_BUSY: assert property (statusByte[0] |-> !writeStart)
        else $error("write started while busy");
    AST_NO_READ_BUSY: assert property (statusByte[0] |-> !arrayReadGo)
        else $error("array read while busy");
    AST_SUPPLY_DROP: assert property ($fell(supplyOk) |-> ##[1:8] !standby)
        else $error("standby held after supply loss");
    AST_POR_IDLE: assert property (!standby && !$past(standby) |-> statusByte == 8'h00
        && !serialOutEn && !writeStart)
        else $error("activity while in power-on reset");
endmodule // seg_guard_assertions

// File: verification/seg_host_model.sv
// spi mode 0 host model driving the guard's serial pins
`timescale 1ns/1ps
module seg_host_model
(
    // clock
    input wire logic mclk,
    // serial pins
    output logic chipSelectN,
    output logic serialClk,
    output logic serialIn,
    input wire logic serialOut
);
    initial
    begin
        chipSelectN = 1'b1;
        serialClk = 1'b0;
        serialIn = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // msb first; rx keeps the last eight bits seen on the output
    task automatic frame(input logic [47:0] bits, input int n, output logic [7:0] rx);
        rx = 8'h00;
        tick(1);
        chipSelectN = 1'b0;
        tick(4);
        for (int i = n - 1; i >= 0; i--)
        begin
            serialIn = bits[i];
            tick(4);
            serialClk = 1'b1;
            tick(4);
            rx = {rx[6:0], serialOut};
            serialClk = 1'b0;
        end
        tick(4);
        chipSelectN = 1'b1;
        serialIn = ~serialIn;
        tick(8);
    endtask
endmodule // seg_host_model
